// *** verilog/upt_pkg.sv ***
// constants shared by the ulpi phy timing block
`default_nettype none
package upt_pkg;
   // register map, byte addresses on the plain register port
   localparam logic [3:0] UPT_ADDR_CTRL      = 4'h0;
   localparam logic [3:0] UPT_ADDR_STATUS    = 4'h4;
   // control register fields
   localparam int         UPT_CTRL_XCVR_LSB  = 0;
   localparam int         UPT_CTRL_TERM_BIT  = 2;
   localparam int         UPT_CTRL_OPM_LSB   = 3;
   localparam logic [4:0] UPT_CTRL_RESET     = 5'h09; // full-speed, term 0, opmode 01
   // status register fields
   localparam int         UPT_STAT_LS_LSB    = 0;
   localparam int         UPT_STAT_TXBUSY    = 2;
   localparam int         UPT_STAT_RXACT     = 3;
   localparam int         UPT_STAT_PREBUSY   = 4;
   // transceiver select and operating mode codes
   localparam logic [1:0] UPT_XCVR_HS        = 2'h0;
   localparam logic [1:0] UPT_XCVR_FS        = 2'h1;
   localparam logic [1:0] UPT_XCVR_LS        = 2'h2;
   localparam logic [1:0] UPT_XCVR_PRE       = 2'h3;
   localparam logic [1:0] UPT_OPM_NORMAL     = 2'h0;
   localparam logic [1:0] UPT_OPM_CHIRP      = 2'h2;
   // line state codes
   localparam logic [1:0] UPT_LS_SE0         = 2'h0;
   localparam logic [1:0] UPT_LS_HS_ACTIVE   = 2'h1;
   localparam logic [1:0] UPT_LS_HS_SQUELCH  = 2'h2;
   localparam logic [1:0] UPT_LS_CHIRP_J     = 2'h1;
   localparam logic [1:0] UPT_LS_CHIRP_K     = 2'h2;
   // pipeline delays in interface clocks (lowest figure of each range)
   localparam logic [7:0] UPT_RXCMD_JK       = 8'h04; // 4 at all speeds
   localparam logic [7:0] UPT_RXCMD_SE0_HS   = 8'h04; // 4
   localparam logic [7:0] UPT_RXCMD_SE0_FS   = 8'h04; // 4 to 6
   localparam logic [7:0] UPT_RXCMD_SE0_LS   = 8'h10; // 16 to 18
   localparam logic [7:0] UPT_TXSTART_HS     = 8'h01; // 1 to 2
   localparam logic [7:0] UPT_TXSTART_FS     = 8'h06; // 6 to 10
   localparam logic [7:0] UPT_TXSTART_LS     = 8'h4a; // 74 to 75
   localparam logic [7:0] UPT_TXEND_PKT      = 8'h03; // 3 to 4
   localparam logic [7:0] UPT_TXEND_SOF      = 8'h06; // 6 to 9
   localparam logic [7:0] UPT_RXSTART_HS     = 8'h05; // 5 to 6
   localparam logic [7:0] UPT_RXEND_HS       = 8'h05; // 5 to 6
   localparam logic [7:0] UPT_RXEND_FS       = 8'h11; // 17 to 18
   localparam logic [7:0] UPT_RXEND_LS       = 8'h7a; // 122 to 123
   // full-speed bit time and the clock period, in picoseconds
   localparam int         UPT_CLK_PS         = 8000;
   localparam int         UPT_FS_BIT_PS      = 83333;
   localparam int         UPT_FS_BIT_CYC_I   = (UPT_FS_BIT_PS + UPT_CLK_PS - 1) / UPT_CLK_PS;
   localparam logic [7:0] UPT_FS_BIT_CYC     = UPT_FS_BIT_CYC_I[7:0];
   // preamble framing, in full-speed bits
   localparam logic [4:0] UPT_PRE_HDR_BITS   = 5'h10; // sync plus pre pid
   localparam logic [4:0] UPT_PRE_J_BITS     = 5'h01; // driven j after the pid
   localparam logic [4:0] UPT_PRE_GAP_BITS   = 5'h04; // gap before low-speed sync
   // speed classes
   typedef enum logic [1:0] {UPT_SPD_HS = 2'h0, UPT_SPD_FS = 2'h1, UPT_SPD_LS = 2'h2} upt_spd_t;
endpackage
`default_nettype wire

// *** verilog/upt_delay.sv ***
// one-shot delay line: pulses a fixed number of clocks after a trigger
`default_nettype none
module upt_delay
   import upt_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // trigger and length
   input  wire logic       i_fire,
   input  wire logic [7:0] i_cycles,
   // result
   output logic            o_pulse,
   output logic            o_busy
);
   logic [7:0] cnt_reg;

   // a new trigger restarts the count; only one event is in flight at a time
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         cnt_reg <= 8'h00;
      else if (i_fire)
         cnt_reg <= i_cycles;
      else if (cnt_reg != 8'h00)
         cnt_reg <= cnt_reg - 8'h01;
   end

   // pulse lands exactly i_cycles edges after the trigger edge
   assign o_pulse = (cnt_reg == 8'h01);
   assign o_busy  = (cnt_reg != 8'h00);
endmodule
`default_nettype wire

// *** verilog/upt_timing.sv ***
// phy-side chirp line state, pipeline delays and preamble sequencing
`default_nettype none
// Summary of operation
// [R01] host link classifies low or full speed
// [R02] host reset writes hs select, term 0
// [R03] host reads chirp line state with receiver
// [R04] peripheral waits se0 then enters chirp
// [R05] peripheral sends chirp k 1..7 ms
// [R06] sleeping peripheral restarts clock in time
// [R07] host keeps se0 if no chirp
// [R08] host answers with alternating k and j
// [R09] host chirp states last 40..60 us
// [R10] peripheral enters hs after kjkjkj
// [R11] hs line state: active 01, squelch 10
// [R12] host returns to normal opmode after chirp
// [R13] rxcmd delay per line change and speed
// [R14] hs transmit start and end delays
// [R15] receive delays and fs/ls tx start
// [R16] host waits between consecutive transmits
// [R17] link answers 1..14 clocks after receive
// [R18] peripheral accepts packets one clock apart
// [R19] link times out after response window
// [R20] select 11 gives preamble mode, fs edges
// [R21] preamble header prepended at full speed
// [R22] four bit gap, driven j after pid
// [R23] all counts in interface clocks
module upt_timing
   import upt_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // register port
   input  wire logic [3:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   output logic [7:0]      o_reg_rdata,
   // analog front-end observations
   input  wire logic       i_line_chg,
   input  wire logic [1:0] i_line_raw,
   input  wire logic       i_squelch,
   input  wire logic       i_hs_diff,
   input  wire logic       i_rx_sync,
   input  wire logic       i_rx_eop,
   // link transmit requests
   input  wire logic       i_tx_cmd,
   input  wire logic       i_tx_sof,
   input  wire logic       i_tx_stop,
   // receive command and packet events toward the link
   output logic            o_rxcmd_valid,
   output logic [1:0]      o_rxcmd_line,
   output logic            o_rx_start,
   output logic            o_rx_end,
   // transmit events toward the line
   output logic            o_tx_start,
   output logic            o_tx_end,
   // preamble line control
   output logic            o_pre_hdr,
   output logic            o_pre_drive_j,
   output logic            o_ls_rate,
   output logic            o_fs_edges
);
   // preamble sequencer states
   typedef enum logic [4:0] {
      UPT_PRE_IDLE = 5'h01,
      UPT_PRE_HDR  = 5'h02,
      UPT_PRE_J    = 5'h04,
      UPT_PRE_GAP  = 5'h08,
      UPT_PRE_LS   = 5'h10
   } upt_pre_t;

   logic [4:0] ctrl_reg;
   logic [7:0] rdata_reg;
   logic [1:0] rxcmd_line_reg;
   logic [1:0] line_pend_reg;
   logic       sof_reg;
   logic       rx_act_reg;
   upt_pre_t   pre_reg;
   logic [7:0] bit_cnt_reg;
   logic [4:0] bits_reg;

   logic [1:0] xcvr;
   logic [1:0] opmode;
   upt_spd_t   spd;
   logic [1:0] line_now;
   logic [7:0] rxcmd_cyc;
   logic [7:0] txs_cyc;
   logic [7:0] txe_cyc;
   logic [7:0] rxe_cyc;
   logic       pre_mode;
   logic       pre_go;
   logic       tx_fire;
   logic       rxcmd_pulse;
   logic       txs_busy;
   logic       txe_busy;
   logic       fs_bit_end;

   // speed class from the transceiver select code; preamble runs at full speed
   function automatic upt_spd_t upt_speed(input logic [1:0] sel);
      unique case (sel)
         UPT_XCVR_HS:  upt_speed = UPT_SPD_HS;
         UPT_XCVR_LS:  upt_speed = UPT_SPD_LS;
         UPT_XCVR_FS:  upt_speed = UPT_SPD_FS;
         UPT_XCVR_PRE: upt_speed = UPT_SPD_FS; // [R20]
      endcase
   endfunction

   // picks one of three per-speed delay figures
   function automatic logic [7:0] upt_pick(input upt_spd_t s, input logic [7:0] hs,
                                           input logic [7:0] fs, input logic [7:0] ls);
      unique case (s)
         UPT_SPD_HS: upt_pick = hs;
         UPT_SPD_FS: upt_pick = fs;
         UPT_SPD_LS: upt_pick = ls;
         default:    upt_pick = fs;
      endcase
   endfunction

   assign xcvr     = ctrl_reg[UPT_CTRL_XCVR_LSB +: 2];
   assign opmode   = ctrl_reg[UPT_CTRL_OPM_LSB +: 2];
   assign spd      = upt_speed(xcvr);
   assign pre_mode = (xcvr == UPT_XCVR_PRE); // [R20]

   // control register written by software steers speed and line reporting
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         ctrl_reg <= UPT_CTRL_RESET;
      else if (i_reg_wr && (i_reg_addr == UPT_ADDR_CTRL))
         ctrl_reg <= i_reg_wdata[4:0];
   end

   // read data stands in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         rdata_reg <= 8'h00;
      else if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            UPT_ADDR_CTRL:   rdata_reg <= {3'h0, ctrl_reg};
            UPT_ADDR_STATUS: rdata_reg <= {3'h0, (pre_reg != UPT_PRE_IDLE), rx_act_reg,
                                           txs_busy | txe_busy, rxcmd_line_reg};
            default:         rdata_reg <= 8'h00;
         endcase
      end
      else
         rdata_reg <= 8'h00;
   end
   assign o_reg_rdata = rdata_reg;

   // reported line state: squelch based in hs, receiver qualified in chirp mode
   always_comb
   begin
      if (spd == UPT_SPD_HS && opmode == UPT_OPM_CHIRP)
         line_now = i_squelch ? UPT_LS_SE0 : (i_hs_diff ? UPT_LS_CHIRP_J : UPT_LS_CHIRP_K);
      else if (spd == UPT_SPD_HS)
         line_now = i_squelch ? UPT_LS_HS_SQUELCH : UPT_LS_HS_ACTIVE; // [R11]
      else
         line_now = i_line_raw;
   end

   // se0 reporting is slower than j or k at low speed; at full speed both take 4 clocks
   assign rxcmd_cyc = (line_now == UPT_LS_SE0 && spd != UPT_SPD_HS) ?
                      upt_pick(spd, UPT_RXCMD_SE0_HS, UPT_RXCMD_SE0_FS, UPT_RXCMD_SE0_LS) :
                      UPT_RXCMD_JK; // [R13]

   // state is sampled at the change so the report carries the right value
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         line_pend_reg <= UPT_LS_SE0;
      else if (i_line_chg)
         line_pend_reg <= line_now;
   end

   upt_delay u_rxcmd_dly (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_fire    (i_line_chg),
      .i_cycles  (rxcmd_cyc),
      .o_pulse   (rxcmd_pulse),
      .o_busy    ()
   ); // [R13]

   // receive command data comes from a flop, held until the next report
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         rxcmd_line_reg <= UPT_LS_SE0;
      else if (rxcmd_pulse)
         rxcmd_line_reg <= line_pend_reg;
   end
   assign o_rxcmd_valid = rxcmd_pulse;
   assign o_rxcmd_line  = rxcmd_line_reg;

   // receive start is timed only for high speed; fs and ls give no start pulse
   upt_delay u_rxs_dly (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_fire    (i_rx_sync && spd == UPT_SPD_HS),
      .i_cycles  (UPT_RXSTART_HS),
      .o_pulse   (o_rx_start),
      .o_busy    ()
   ); // [R15]

   assign rxe_cyc = upt_pick(spd, UPT_RXEND_HS, UPT_RXEND_FS, UPT_RXEND_LS);

   upt_delay u_rxe_dly (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_fire    (i_rx_eop),
      .i_cycles  (rxe_cyc),
      .o_pulse   (o_rx_end),
      .o_busy    ()
   ); // [R15]

   // receive activity seen by software, framed by the delayed edges
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         rx_act_reg <= 1'b0;
      else if (o_rx_start)
         rx_act_reg <= 1'b1;
      else if (o_rx_end)
         rx_act_reg <= 1'b0;
   end

   // in preamble mode the header goes first and the start is issued later
   assign pre_go  = i_tx_cmd && pre_mode && (pre_reg == UPT_PRE_IDLE);
   assign tx_fire = (i_tx_cmd && !pre_mode) ||
                    (pre_reg == UPT_PRE_GAP && fs_bit_end && bits_reg == 5'h01);
   assign txs_cyc = pre_mode ? UPT_TXSTART_LS :
                    upt_pick(spd, UPT_TXSTART_HS, UPT_TXSTART_FS, UPT_TXSTART_LS);

   upt_delay u_txs_dly (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_fire    (tx_fire),
      .i_cycles  (txs_cyc),
      .o_pulse   (o_tx_start),
      .o_busy    (txs_busy)
   ); // [R14] [R15]

   // remember whether the packet in flight is a start-of-frame
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         sof_reg <= 1'b0;
      else if (i_tx_cmd)
         sof_reg <= i_tx_sof;
   end

   // sof needs the long eop, hence the longer end latency
   assign txe_cyc = sof_reg ? UPT_TXEND_SOF : UPT_TXEND_PKT; // [R14]

   upt_delay u_txe_dly (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_fire    (i_tx_stop && spd == UPT_SPD_HS),
      .i_cycles  (txe_cyc),
      .o_pulse   (o_tx_end),
      .o_busy    (txe_busy)
   ); // [R14]

   // full-speed bit timer; bit length rounded up so no bit runs short
   assign fs_bit_end = (bit_cnt_reg == 8'h01);
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         bit_cnt_reg <= 8'h00;
      else if (pre_go || (fs_bit_end && pre_reg != UPT_PRE_LS))
         bit_cnt_reg <= UPT_FS_BIT_CYC; // [R23]
      else if (bit_cnt_reg != 8'h00)
         bit_cnt_reg <= bit_cnt_reg - 8'h01;
   end

   // preamble sequencer: header, driven j, idle gap, then low-speed packet
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pre_reg  <= UPT_PRE_IDLE;
         bits_reg <= 5'h00;
      end
      else
      begin
         unique case (pre_reg)
            UPT_PRE_IDLE:
               if (pre_go)
               begin
                  pre_reg  <= UPT_PRE_HDR; // [R21]
                  bits_reg <= UPT_PRE_HDR_BITS;
               end
            UPT_PRE_HDR:
               if (fs_bit_end && bits_reg == 5'h01)
               begin
                  pre_reg  <= UPT_PRE_J;
                  bits_reg <= UPT_PRE_J_BITS; // [R22]
               end
               else if (fs_bit_end)
                  bits_reg <= bits_reg - 5'h01;
            UPT_PRE_J:
               if (fs_bit_end)
               begin
                  pre_reg  <= UPT_PRE_GAP;
                  bits_reg <= UPT_PRE_GAP_BITS - UPT_PRE_J_BITS; // [R22]
               end
            UPT_PRE_GAP:
               if (fs_bit_end && bits_reg == 5'h01)
                  pre_reg <= UPT_PRE_LS;
               else if (fs_bit_end)
                  bits_reg <= bits_reg - 5'h01;
            UPT_PRE_LS:
               if (i_tx_stop || !pre_mode)
                  pre_reg <= UPT_PRE_IDLE; // low-speed body runs until the link stops or preamble select is left
            default:
               pre_reg <= UPT_PRE_IDLE;
         endcase
      end
   end

   // line control: j counts toward the four-bit gap, packet body at low rate
   assign o_pre_hdr     = (pre_reg == UPT_PRE_HDR); // [R21]
   assign o_pre_drive_j = (pre_reg == UPT_PRE_J);   // [R22]
   assign o_ls_rate     = (pre_reg == UPT_PRE_LS) || (spd == UPT_SPD_LS && !pre_mode);
   assign o_fs_edges    = (spd == UPT_SPD_FS); // [R20]
endmodule
`default_nettype wire

// *** test/upt_timing_checker.sv ***
// port-level timing checks for the ulpi phy timing block
`default_nettype none
module upt_timing_checker
   import upt_pkg::*;
(
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   // inputs watched
   input wire logic [3:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_wr,
   input wire logic       i_line_chg,
   input wire logic       i_rx_sync,
   input wire logic       i_rx_eop,
   input wire logic       i_tx_cmd,
   input wire logic       i_tx_sof,
   input wire logic       i_tx_stop,
   // outputs watched
   input wire logic       o_rxcmd_valid,
   input wire logic       o_rx_start,
   input wire logic       o_rx_end,
   input wire logic       o_tx_start,
   input wire logic       o_tx_end,
   input wire logic       o_pre_hdr,
   input wire logic       o_pre_drive_j,
   input wire logic       o_ls_rate,
   input wire logic       o_fs_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] sel_reg;
   logic       sof_reg;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // shadow of transceiver select, lands on the same edge as the real register
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         sel_reg <= UPT_XCVR_FS;
      else if (i_reg_wr && i_reg_addr == UPT_ADDR_CTRL)
         sel_reg <= i_reg_wdata[1:0];
   end
   // frame kind of the last transmit, needed to pick the end delay
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         sof_reg <= 1'b0;
      else if (i_tx_cmd)
         sof_reg <= i_tx_sof;
   end
   chk_rxcmd_cause: assert property (
      o_rxcmd_valid |-> $past(i_line_chg, 4) || $past(i_line_chg, 16))
      else $error("receive command without a matching line change");
   chk_hs_txstart: assert property (
      i_tx_cmd && sel_reg == UPT_XCVR_HS |=> o_tx_start)
      else $error("hs transmit start late");
   chk_hs_txend: assert property (
      i_tx_stop && sel_reg == UPT_XCVR_HS && !sof_reg |-> ##3 o_tx_end)
      else $error("hs packet end delay wrong");
   chk_sof_txend: assert property (
      i_tx_stop && sel_reg == UPT_XCVR_HS && sof_reg |-> ##6 o_tx_end)
      else $error("hs frame start end delay wrong");
   chk_hs_rxstart: assert property (
      i_rx_sync && sel_reg == UPT_XCVR_HS |-> ##5 o_rx_start)
      else $error("hs receive start delay wrong");
   chk_fs_rxend: assert property (
      i_rx_eop && sel_reg == UPT_XCVR_FS |-> ##17 o_rx_end)
      else $error("fs receive end delay wrong");
   chk_edge_rate: assert property (
      o_fs_edges == (sel_reg == UPT_XCVR_FS || sel_reg == UPT_XCVR_PRE))
      else $error("edge rate does not follow select");
   chk_pre_order: assert property (
      o_pre_hdr |-> !o_ls_rate && !o_tx_start)
      else $error("low-speed traffic during preamble header");
   chk_pre_gap: assert property (
      $rose(o_pre_drive_j) |-> o_pre_drive_j [*8] ##1 !o_ls_rate [*8])
      else $error("driven j or gap too short");
   cover property (o_tx_end);
   cover property (o_pre_drive_j);
   cover property (o_rx_end);
endmodule
`default_nettype wire

// *** test/upt_link_model.sv ***
// link-side transmit model: command, stop after a length, then response window
`default_nettype none
module upt_link_model
   import upt_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // bench control
   input  wire logic       i_go,
   input  wire logic       i_sof,
   input  wire logic [8:0] i_len,
   // toward the phy; busy goes back to the bench
   output logic            o_tx_cmd,
   output logic            o_tx_sof,
   output logic            o_tx_stop,
   output logic            o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] len_reg;
   logic [6:0] gap_reg;
   logic       act_reg;
   // no new packet until the response window has run out
   assign o_busy = act_reg || gap_reg != 7'h00 || o_tx_cmd;
   // one packet at a time, all counts in interface clocks
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_tx_cmd <= 1'b0;
         o_tx_sof <= 1'b0;
         o_tx_stop <= 1'b0;
         act_reg <= 1'b0;
         len_reg <= 9'h000;
         gap_reg <= 7'h00;
      end
      else
      begin
         o_tx_cmd <= 1'b0;
         o_tx_stop <= 1'b0;
         if (i_go && !o_busy)
         begin
            o_tx_cmd <= 1'b1;
            o_tx_sof <= i_sof;
            len_reg <= i_len;
            act_reg <= 1'b1;
         end
         else if (act_reg && len_reg == 9'h000)
         begin
            o_tx_stop <= 1'b1;
            act_reg <= 1'b0;
            gap_reg <= 7'h5c;
         end
         else if (act_reg)
            len_reg <= len_reg - 9'h001;
         else if (gap_reg != 7'h00)
            gap_reg <= gap_reg - 7'h01;
      end
   end
endmodule
`default_nettype wire

// *** test/upt_timing_tb.sv ***
// self-checking bench for the ulpi phy timing block
`default_nettype none
module upt_timing_tb
   import upt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_clk, i_sys_rst, wr, rd, sq, df, go, sof;
   logic [3:0] addr;
   logic [7:0] wd;
   logic [2:0] fe;
   logic [1:0] raw;
   logic [8:0] len;
   wire logic [7:0] rdata;
   wire logic [1:0] rxl;
   wire logic       txc, txf, txp, busy, rxv, rxs, rxe, txs, txe, hdr, dj, lsr, fse;
   wire logic [7:0] ob;
   wire logic [1:0] tr;
   int failures;
   int compares;
   assign ob = {hdr, lsr, dj, txe, txs, rxe, rxs, rxv};
   assign tr = {txp, txc};
   upt_timing u_upt_timing (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_line_chg(fe[0]), .i_line_raw(raw), .i_squelch(sq), .i_hs_diff(df),
      .i_rx_sync(fe[1]), .i_rx_eop(fe[2]), .i_tx_cmd(txc), .i_tx_sof(txf), .i_tx_stop(txp),
      .o_rxcmd_valid(rxv), .o_rxcmd_line(rxl), .o_rx_start(rxs), .o_rx_end(rxe),
      .o_tx_start(txs), .o_tx_end(txe), .o_pre_hdr(hdr), .o_pre_drive_j(dj),
      .o_ls_rate(lsr), .o_fs_edges(fse));
   upt_link_model u_upt_link_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go),
      .i_sof(sof), .i_len(len), .o_tx_cmd(txc), .o_tx_sof(txf), .o_tx_stop(txp), .o_busy(busy));
   // free-running 125 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe edge
   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk("rdata", rdata, e);
   endtask
   // called at the taking edge: counts edges until the output is sampled high
   task automatic meas(input int k, input int n);
      int c;
      c = 1;
      #1;
      while (ob[k] !== 1'b1 && c < 400)
      begin
         @(posedge i_clk);
         #1 c++;
      end
      chk("delay", c[15:0], n[15:0]);
   endtask
   task automatic trg(input int k);
      int c;
      c = 0;
      #1;
      while (tr[k] !== 1'b1 && c < 600)
      begin
         @(posedge i_clk);
         #1 c++;
      end
   endtask
   task automatic ev(input int k, input int o, input int n);
      @(posedge i_clk);
      fe[k] <= 1'b1;
      @(posedge i_clk);
      fe[k] <= 1'b0;
      meas(o, n);
   endtask
   task automatic lc(input logic [1:0] r, input logic q, input logic d, input int n,
                     input logic [1:0] l);
      @(posedge i_clk);
      raw <= r;
      sq <= q;
      df <= d;
      fe[0] <= 1'b1;
      @(posedge i_clk);
      fe[0] <= 1'b0;
      meas(0, n);
      @(posedge i_clk);
      #1 chk("line", {14'h0000, rxl}, {14'h0000, l});
   endtask
   // one link packet; e nonzero also times the end after stop
   task automatic tx(input logic s, input logic [8:0] ln, input int o, input int n, input int e);
      while (busy !== 1'b0)
         @(posedge i_clk);
      @(posedge i_clk);
      go <= 1'b1;
      sof <= s;
      len <= ln;
      @(posedge i_clk);
      go <= 1'b0;
      trg(0);
      // the phy takes the command at the edge after it appears
      @(posedge i_clk);
      meas(o, n);
      if (e != 0)
      begin
         trg(1);
         @(posedge i_clk);
         meas(4, e);
      end
   endtask
   // watchdog well above the under one thousand cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge i_clk);
      failures++;
      end_sim();
   end
   initial
   begin
      {i_sys_rst, wr, rd, sq, df, go, sof} = 7'h40;
      {addr, wd, fe, raw, len} = 26'h0000000;
      failures = 0;
      compares = 0;
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rreg(UPT_ADDR_CTRL, {3'h0, UPT_CTRL_RESET});
      wreg(4'h8, 8'hff);
      rreg(4'h8, 8'h00);
      rreg(UPT_ADDR_CTRL, {3'h0, UPT_CTRL_RESET});
      lc(2'h1, 1'b0, 1'b0, 4, 2'h1);
      lc(2'h0, 1'b0, 1'b0, 4, 2'h0);
      ev(2, 2, 17);
      tx(1'b0, 9'h014, 3, 6, 0);
      wreg(UPT_ADDR_CTRL, 8'h0a);
      lc(2'h0, 1'b0, 1'b0, 16, 2'h0);
      lc(2'h1, 1'b0, 1'b0, 4, 2'h1);
      ev(2, 2, 122);
      tx(1'b0, 9'h064, 3, 74, 0);
      // chirp: high-speed select, term 0, opmode 10
      wreg(UPT_ADDR_CTRL, 8'h10);
      rreg(UPT_ADDR_CTRL, 8'h10);
      lc(2'h0, 1'b0, 1'b0, 4, UPT_LS_CHIRP_K);
      lc(2'h0, 1'b0, 1'b1, 4, UPT_LS_CHIRP_J);
      lc(2'h0, 1'b1, 1'b0, 4, UPT_LS_SE0);
      wreg(UPT_ADDR_CTRL, 8'h00);
      lc(2'h0, 1'b1, 1'b0, 4, UPT_LS_HS_SQUELCH);
      lc(2'h0, 1'b0, 1'b0, 4, UPT_LS_HS_ACTIVE);
      ev(1, 1, 5);
      rreg(UPT_ADDR_STATUS, 8'h09);
      ev(2, 2, 5);
      tx(1'b0, 9'h004, 3, 1, 3);
      tx(1'b1, 9'h004, 3, 1, 6);
      wreg(UPT_ADDR_CTRL, 8'h03);
      rreg(UPT_ADDR_CTRL, 8'h03);
      chk("edges", {15'h0000, fse}, 16'h0001);
      tx(1'b0, 9'h190, 7, 1, 0);
      meas(5, 177);
      // counted from the edge that raised the driven j: j plus gap, then one
      meas(6, 45);
      meas(3, 74);
      end_sim();
   end
endmodule
bind upt_timing upt_timing_checker u_upt_timing_checker (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .i_line_chg(i_line_chg), .i_rx_sync(i_rx_sync), .i_rx_eop(i_rx_eop), .i_tx_cmd(i_tx_cmd),
   .i_tx_sof(i_tx_sof), .i_tx_stop(i_tx_stop), .o_rxcmd_valid(o_rxcmd_valid),
   .o_rx_start(o_rx_start), .o_rx_end(o_rx_end), .o_tx_start(o_tx_start), .o_tx_end(o_tx_end),
   .o_pre_hdr(o_pre_hdr), .o_pre_drive_j(o_pre_drive_j), .o_ls_rate(o_ls_rate),
   .o_fs_edges(o_fs_edges));
`default_nettype wire
